// ===== hw/device_config_status.v
// apb slave reporting the reset-time device configuration
`timescale 1ns/100ps
`include "device_config_status_consts.vh"
module device_config_status #(
	parameter CFG_W = 11
) (
	input wire core_clk_i,
	input wire arst_n_i,
	// apb slave port
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [31:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	// configuration straps, sampled after reset release
	input wire ethernet_block_enable_i,
	input wire host_port_bus_width_i,
	input wire pci_eeprom_autoload_i,
	input wire pci_enable_i,
	input wire [1:0] cpu_clock_multiplier_mode_i,
	input wire byte_order_select_i,
	input wire [1:0] boot_mode_i,
	input wire [1:0] memory_interface_clock_source_i,
	// configuration as used by the rest of the chip
	output reg config_valid_o,
	output reg ethernet_block_enable_o,
	output reg host_port_bus_width_o,
	output reg host_port_pins_enable_o,
	output reg pci_enable_o,
	output reg pci_eeprom_autoload_o,
	output reg [1:0] cpu_clock_multiplier_mode_o,
	output reg byte_order_select_o,
	output reg boot_host_port_o,
	output reg boot_pci_o,
	output reg boot_memory_o,
	output reg [1:0] memory_interface_clock_source_o,
	output reg config_fault_o
);

	// capture sequencer states
	localparam ST_WAIT = 2'b00;
	localparam ST_CAPTURE = 2'b01;
	localparam ST_HELD = 2'b10;

	// flags whether a two-bit code equals its reserved value
	function code_is_reserved;
		input [1:0] code;
		input [1:0] rsv;
		begin
			code_is_reserved = (code == rsv);
		end
	endfunction

	// builds the status word; bits 31:12 and 7 stay zero
	function [31:0] status_word;
		input [CFG_W-1:0] cfg;
		begin
			status_word = 32'h0000_0000;
			status_word[11:8] = cfg[10:7];
			status_word[6:0] = cfg[6:0];
		end
	endfunction

	// true when a bus address selects the given register word
	function addr_hit;
		input [31:0] addr;
		input [31:0] base;
		begin
			addr_hit = (addr == base);
		end
	endfunction

	wire [CFG_W-1:0] raw_straps;
	wire [CFG_W-1:0] sync_straps;
	wire straps_agree;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [7:0] settle_ff;
	reg [7:0] nxt_settle;
	reg [7:0] wait_ff;
	reg [7:0] nxt_wait;
	reg [CFG_W-1:0] cfg_ff;
	reg [`DCS_CHECK_W-1:0] mask_ff;
	reg [`DCS_CHECK_W-1:0] nxt_mask;
	reg [`DCS_CHECK_W-1:0] flag_ff;

	wire access_phase;
	wire commit;
	wire hit_status;
	wire hit_check;
	reg [31:0] nxt_rdata;
	reg nxt_slverr;
	wire answer_now;

	// packed in the same order as the status word bits 11:8 and 6:0
	assign raw_straps = {
		ethernet_block_enable_i,
		host_port_bus_width_i,
		pci_eeprom_autoload_i,
		pci_enable_i,
		cpu_clock_multiplier_mode_i,
		byte_order_select_i,
		boot_mode_i,
		memory_interface_clock_source_i
	};

	// straps come from board pins, so they cross into the core clock first
	strap_sync #(
		.WIDTH(CFG_W)
	) u_strap_sync (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.strap_i(raw_straps),
		.strap_o(sync_straps),
		.agree_o(straps_agree)
	);

	// capture sequencer: wait for quiet straps, then latch once
	always @* begin
		nxt_state = state_ff;
		nxt_settle = settle_ff;
		nxt_wait = wait_ff;
		case (state_ff)
			ST_WAIT: begin
				if (wait_ff != `DCS_CAPTURE_LIMIT) begin
					nxt_wait = wait_ff + 8'h01;
				end
				// any disagreement restarts the count, so a bouncing strap delays capture
				if (!straps_agree) begin
					nxt_settle = 8'h00;
				end else if (settle_ff != `DCS_SETTLE_CYCLES) begin
					nxt_settle = settle_ff + 8'h01;
				end
				// a strap that never settles must not stall the chip forever
				if (settle_ff == `DCS_SETTLE_CYCLES || wait_ff == `DCS_CAPTURE_LIMIT) begin
					nxt_state = ST_CAPTURE;
				end
			end
			ST_CAPTURE: begin
				nxt_state = ST_HELD;
			end
			ST_HELD: begin
				// only a reset leaves this state
				nxt_state = ST_HELD;
			end
			default: begin
				nxt_state = ST_WAIT;
			end
		endcase
	end

	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff <= ST_WAIT;
			settle_ff <= 8'h00;
			wait_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			settle_ff <= nxt_settle;
			wait_ff <= nxt_wait;
		end
	end

	// configuration is latched exactly once per reset
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_ff <= `DCS_RESET_CFG;
		end else if (state_ff == ST_CAPTURE) begin
			cfg_ff <= sync_straps;
		end
	end

	// reserved codes are recorded so software can spot a bad strap setting
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag_ff <= {`DCS_CHECK_W{1'b0}};
		end else if (state_ff == ST_CAPTURE) begin
			flag_ff[0] <= code_is_reserved(sync_straps[6:5], `DCS_CPU_CLOCK_MULTIPLIER_MODE_RSV);
			flag_ff[1] <= code_is_reserved(sync_straps[3:2], `DCS_BOOT_RSV);
			flag_ff[2] <= code_is_reserved(sync_straps[1:0], `DCS_CLKSRC_RSV);
		end
	end

	// captured fields by name; above the reserved bit the cfg index is one below
	wire cap_eth;
	wire cap_width;
	wire cap_eeprom;
	wire cap_pci;
	wire [1:0] cap_cpu_clock_multiplier_mode;
	wire cap_endian;
	wire [1:0] cap_boot;
	wire [1:0] cap_clksrc;

	assign cap_eth = cfg_ff[10];
	assign cap_width = cfg_ff[9];
	assign cap_eeprom = cfg_ff[8];
	assign cap_pci = cfg_ff[7];
	assign cap_cpu_clock_multiplier_mode = cfg_ff[6:5];
	assign cap_endian = cfg_ff[4];
	assign cap_boot = cfg_ff[3:2];
	assign cap_clksrc = cfg_ff[1:0];

	// valid rises a cycle after the held state, once the outputs below have settled
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			config_valid_o <= 1'b0;
		end else begin
			config_valid_o <= (state_ff == ST_HELD);
		end
	end

	// pin ownership: pci takes the shared pins, so the ethernet enable is ignored then
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ethernet_block_enable_o <= 1'b0;
			host_port_pins_enable_o <= 1'b0;
			pci_enable_o <= 1'b0;
			pci_eeprom_autoload_o <= 1'b0;
		end else begin
			ethernet_block_enable_o <= cap_eth & ~cap_pci;
			host_port_pins_enable_o <= ~cap_pci;
			pci_enable_o <= cap_pci;
			// eeprom load only means something with pci switched on
			pci_eeprom_autoload_o <= cap_eeprom & cap_pci;
		end
	end

	// plain copies of the width, clock and byte order settings
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			host_port_bus_width_o <= 1'b0;
			cpu_clock_multiplier_mode_o <= 2'h0;
			byte_order_select_o <= 1'b1;
			memory_interface_clock_source_o <= 2'h0;
		end else begin
			host_port_bus_width_o <= cap_width;
			cpu_clock_multiplier_mode_o <= cap_cpu_clock_multiplier_mode;
			byte_order_select_o <= cap_endian;
			memory_interface_clock_source_o <= cap_clksrc;
		end
	end

	// host-port boot goes to pci or host port depending on pci enable
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			boot_host_port_o <= 1'b0;
			boot_pci_o <= 1'b0;
			boot_memory_o <= 1'b0;
		end else begin
			boot_host_port_o <= (cap_boot == `DCS_BOOT_HOST) & ~cap_pci;
			boot_pci_o <= (cap_boot == `DCS_BOOT_HOST) & cap_pci;
			// no boot and the reserved code both leave every boot output low
			boot_memory_o <= (cap_boot == `DCS_BOOT_MEM);
		end
	end

	// a masked-in reserved code raises the fault level; masked out it stays quiet
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			config_fault_o <= 1'b0;
		end else begin
			config_fault_o <= |(flag_ff & mask_ff);
		end
	end

	// apb decode: status word and check register only; any other address
	// answers with an error so that a stray pointer shows up in software
	assign access_phase = psel_i & penable_i;
	assign commit = access_phase & pready_o;
	assign answer_now = access_phase & ~pready_o;
	assign hit_status = addr_hit(paddr_i, `DCS_STATUS_ADDR);
	assign hit_check = addr_hit(paddr_i, `DCS_CHECK_ADDR);

	// read data and error are prepared in the first access cycle
	always @* begin
		nxt_rdata = 32'h0000_0000;
		nxt_slverr = 1'b0;
		if (hit_status) begin
			nxt_rdata = status_word(cfg_ff);
		end else if (hit_check) begin
			nxt_rdata[`DCS_FLAG_LSB +: `DCS_CHECK_W] = flag_ff;
			nxt_rdata[`DCS_MASK_LSB +: `DCS_CHECK_W] = mask_ff;
		end else begin
			nxt_slverr = 1'b1;
		end
		if (pwrite_i) begin
			nxt_rdata = 32'h0000_0000;
		end
	end

	// one wait state keeps pready and prdata straight from flops
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pready_o <= 1'b0;
		end else begin
			// ready drops after one cycle; an access held past it is answered again every second cycle
			pready_o <= answer_now;
		end
	end

	// read data stands only in the answer cycle and reads zero otherwise
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (answer_now) begin
			prdata_o <= nxt_rdata;
		end else begin
			prdata_o <= 32'h0000_0000;
		end
	end

	// error flag follows the same one-cycle answer window
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pslverr_o <= 1'b0;
		end else if (answer_now) begin
			pslverr_o <= nxt_slverr;
		end else begin
			pslverr_o <= 1'b0;
		end
	end

	// only the mask bits are writable; the status word ignores writes
	always @* begin
		nxt_mask = mask_ff;
		if (commit & pwrite_i & hit_check) begin
			nxt_mask = pwdata_i[`DCS_MASK_LSB +: `DCS_CHECK_W];
		end
	end

	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mask_ff <= `DCS_RESET_MASK;
		end else begin
			mask_ff <= nxt_mask;
		end
	end

endmodule // device_config_status

// ===== hw/device_config_status_consts.vh
// constants for the device configuration status register block
// Notes on behaviour
// - bits 31:12 and 7 reserved, writes ignored
// - bit 11 shows ethernet block enable
// - pci enable overrides the ethernet block enable
// - bit 10 shows host port bus width
// - bit 9 eeprom autoload, only with pci
// - bit 8 pci enable replaces host port pins
// - bits 6:5 cpu clock multiplier mode
// - bit 4 byte order, little endian default
// - bits 3:2 boot mode codes
// - bits 1:0 memory interface clock source
`ifndef DEVICE_CONFIG_STATUS_CONSTS_VH
`define DEVICE_CONFIG_STATUS_CONSTS_VH

// register byte addresses
`define DCS_STATUS_ADDR 32'h01b3f004
`define DCS_CHECK_ADDR 32'h01b3f0f8

// status register field positions
`define DCS_ETH_EN_BIT 11
`define DCS_HP_WIDTH_BIT 10
`define DCS_EEPROM_BIT 9
`define DCS_PCI_EN_BIT 8
`define DCS_CPU_CLOCK_MULTIPLIER_MODE_LSB 5
`define DCS_ENDIAN_BIT 4
`define DCS_BOOT_LSB 2
`define DCS_CLKSRC_LSB 0

// check register field positions
`define DCS_FLAG_LSB 0
`define DCS_MASK_LSB 8
`define DCS_CHECK_W 3

// reset values of captured fields and the mask
`define DCS_RESET_CFG 11'h010
`define DCS_RESET_MASK 3'h0

// field encodings
`define DCS_CPU_CLOCK_MULTIPLIER_MODE_RSV 2'h3
`define DCS_BOOT_NONE 2'h0
`define DCS_BOOT_HOST 2'h1
`define DCS_BOOT_RSV 2'h2
`define DCS_BOOT_MEM 2'h3
`define DCS_CLKSRC_RSV 2'h3

// strap capture timing, in core clock cycles
`define DCS_SETTLE_CYCLES 8'h10
`define DCS_CAPTURE_LIMIT 8'hff

`endif

// ===== hw/strap_sync.v
// three-stage synchroniser for reset-time configuration straps
`timescale 1ns/100ps
module strap_sync #(
	parameter WIDTH = 11
) (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire [WIDTH-1:0] strap_i,
	output reg [WIDTH-1:0] strap_o,
	output reg agree_o
);

	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;
	reg [WIDTH-1:0] hold_ff;
	wire [WIDTH-1:0] nxt_strap;

	// a bit only moves once the second and third stage agree
	assign nxt_strap = (sync_ff & ~(sync_ff ^ hold_ff)) | (strap_o & (sync_ff ^ hold_ff));

	// the first stage feeds nothing but the second
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_ff <= {WIDTH{1'b0}};
			sync_ff <= {WIDTH{1'b0}};
			hold_ff <= {WIDTH{1'b0}};
			strap_o <= {WIDTH{1'b0}};
			agree_o <= 1'b0;
		end else begin
			meta_ff <= strap_i;
			sync_ff <= meta_ff;
			hold_ff <= sync_ff;
			strap_o <= nxt_strap;
			agree_o <= (sync_ff == hold_ff);
		end
	end

endmodule // strap_sync

// ===== tb/device_config_status_properties.sv
// assertions on the ports of the configuration status block
`timescale 1ns/100ps
`include "device_config_status_consts.vh"
module device_config_status_properties (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [31:0] paddr_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	input wire config_valid_o,
	input wire ethernet_block_enable_o,
	input wire pci_enable_o,
	input wire pci_eeprom_autoload_o,
	input wire boot_pci_o,
	input wire host_port_pins_enable_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// first access-phase edge still waiting on the slave
	sequence access_wait;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence status_read;
		pready_o && !pwrite_i && paddr_i == `DCS_STATUS_ADDR;
	endsequence
	ready_wait_a: assert property (access_wait |=> pready_o)
		else $error("ready missing after one wait state");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	unmapped_err_a: assert property (pready_o && paddr_i != `DCS_STATUS_ADDR
		&& paddr_i != `DCS_CHECK_ADDR |-> pslverr_o) else $error("unmapped without error");
	idle_data_a: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside answer");
	reserved_zero_a: assert property (status_read |-> !pslverr_o
		&& prdata_o[31:12] == 20'h0 && !prdata_o[7]) else $error("reserved bits set");
	eth_gate_a: assert property (pci_enable_o |-> !ethernet_block_enable_o)
		else $error("ethernet enabled beside pci");
	eeprom_gate_a: assert property (pci_eeprom_autoload_o |-> pci_enable_o)
		else $error("eeprom load without pci");
	boot_pci_a: assert property (boot_pci_o |-> pci_enable_o)
		else $error("pci boot without pci");
	pins_owner_a: assert property (config_valid_o
		|-> host_port_pins_enable_o != pci_enable_o) else $error("pin owner mismatch");
	hold_cfg_a: assert property (config_valid_o |=> config_valid_o
		&& $stable({ethernet_block_enable_o, pci_enable_o})) else $error("config moved");
endmodule // device_config_status_properties
bind device_config_status device_config_status_properties chk_i (.core_clk_i(core_clk_i),
	.arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.config_valid_o(config_valid_o), .ethernet_block_enable_o(ethernet_block_enable_o),
	.pci_enable_o(pci_enable_o), .pci_eeprom_autoload_o(pci_eeprom_autoload_o),
	.boot_pci_o(boot_pci_o), .host_port_pins_enable_o(host_port_pins_enable_o));

// ===== tb/device_config_status_bench.sv
// self-checking bench for the configuration status block
`timescale 1ns/100ps
`include "device_config_status_consts.vh"
module device_config_status_bench;
	reg core_clk_i, arst_n, psel, penable, pwrite;
	reg [31:0] paddr, pwdata, rd;
	reg [11:0] st;
	reg err;
	wire [31:0] prdata;
	wire [1:0] cm, cs;
	wire pready, pslverr, valid, eth, wid, hpe, pci, ee, bo, bh, bp, bm, flt;
	integer miscompares, total_checks, i, n;
	reg [1:0] b;
	device_config_status uut (.core_clk_i(core_clk_i), .arst_n_i(arst_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.ethernet_block_enable_i(st[11]), .host_port_bus_width_i(st[10]),
		.pci_eeprom_autoload_i(st[9]), .pci_enable_i(st[8]),
		.cpu_clock_multiplier_mode_i(st[6:5]), .byte_order_select_i(st[4]),
		.boot_mode_i(st[3:2]), .memory_interface_clock_source_i(st[1:0]),
		.config_valid_o(valid), .ethernet_block_enable_o(eth), .host_port_bus_width_o(wid),
		.host_port_pins_enable_o(hpe), .pci_enable_o(pci), .pci_eeprom_autoload_o(ee),
		.cpu_clock_multiplier_mode_o(cm), .byte_order_select_o(bo), .boot_host_port_o(bh),
		.boot_pci_o(bp), .boot_memory_o(bm), .memory_interface_clock_source_o(cs),
		.config_fault_o(flt));
	always #10 core_clk_i = ~core_clk_i;
	task chk(input [31:0] s, input [31:0] e);
		begin
			total_checks = total_checks + 1;
			if (s !== e) begin
				miscompares = miscompares + 1;
				$display("unexpected at %0t: seen %h expected %h", $time, s, e);
			end
		end
	endtask
	// called just after an edge; psel stays up so a next setup may follow at once
	task apb(input w, input [31:0] a, input [31:0] d);
		begin
			psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
			@(posedge core_clk_i);
			penable <= 1'b1;
			n = 0;
			do begin @(posedge core_clk_i); n = n + 1; end while (pready !== 1'b1 && n < 20);
			if (n >= 20) miscompares = miscompares + 1;
			rd = prdata;
			err = pslverr;
			penable <= 1'b0;
		end
	endtask
	task final_report;
		begin
			if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
			else $display("Run complete: FAIL");
			$finish;
		end
	endtask
	initial begin
		core_clk_i = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		st = 0; miscompares = 0; total_checks = 0;
		for (i = 0; i < 4; i = i + 1) begin
			// every clock, boot and source code once; pci rides on the top bit
			b = {i[1], i[1] ^ i[0]};
			arst_n <= 1'b0;
			st <= {1'b1, i[0], 1'b1, i[1], 1'b1, i[1:0], ~i[0], b, i[1:0]};
			repeat (3) @(posedge core_clk_i);
			arst_n <= 1'b1;
			@(posedge core_clk_i);
			apb(0, `DCS_STATUS_ADDR, 0); chk(rd, 32'h10);
			apb(1, `DCS_STATUS_ADDR, 32'hffffffff); chk(err, 0);
			psel <= 1'b0;
			n = 0;
			while (valid !== 1'b1 && n < 400) begin @(posedge core_clk_i); n = n + 1; end
			chk(valid, 1);
			apb(0, `DCS_STATUS_ADDR, 0); chk(rd, {20'h0, st & 12'hf7f});
			apb(1, `DCS_STATUS_ADDR, 32'hffffffff);
			apb(0, `DCS_STATUS_ADDR, 0); chk(rd, {20'h0, st & 12'hf7f});
			apb(0, 32'h01b3f008, 0); chk(err, 1);
			chk(rd, 0);
			apb(1, `DCS_CHECK_ADDR, 32'h700);
			apb(0, `DCS_CHECK_ADDR, 0); chk(rd, i == 3 ? 32'h707 : 32'h700);
			psel <= 1'b0;
			st <= ~st;
			repeat (30) @(posedge core_clk_i);
			chk(flt, i == 3);
			chk({eth, hpe, ee, bh, bp, bm}, {~i[1], ~i[1], i[1], b == 1 && !i[1],
				b == 1 && i[1], b == 3});
			chk({wid, pci, cm, bo, cs}, {i[0], i[1], i[1:0], ~i[0], i[1:0]});
			apb(0, `DCS_STATUS_ADDR, 0); chk(rd, {20'h0, ~st & 12'hf7f});
			psel <= 1'b0;
		end
		final_report;
	end
	// whole run is well under 1000 cycles; the limit leaves a wide margin
	initial begin
		#400000;
		miscompares = miscompares + 1;
		final_report;
	end
endmodule // device_config_status_bench
